// ===== logic/ssff_top.sv
// Oscillator select, sync output, power-good reset and fault flag control
// Summary of operation
// - Free running: sync output falls at switch turn-on, rises half a period later.
// - While slaved to external sync, sync output is held low.
// - Following external sync begins no earlier than 2.5 ms after power-good reset rises.
// - Each sync input rising edge, once active, turns the switch on within three core clock cycles.
// - No edge within reassertion timeout: resume own oscillator at its next tick.
// - During foldback ignore sync input timing and hold sync output low.
// - Unused sync input counts as no clock; own oscillator runs.
// - Fault flag asserts on low input voltage or temperature warning.
// - Fault conditions pass a short glitch filter before the flag changes.
// - Fault flag is open drain, only ever drives low.
// - Over-temperature stops switching, resets soft-start, removes gate drive supply.
// - Switching resumes automatically when temperature is safe again.
// - Power-good reset stays low 16 ms after output returns to regulation.
// - High input voltage halves switching frequency; restored when it falls back.
`timescale 1ns/100ps
`include "ssff_regs.svh"
module ssff_top #(
    parameter int SW_PERIOD_CYC   = `SSFF_SW_PERIOD_CYC,   // Own switching period, cycles
    parameter int REASSERT_CYC    = `SSFF_REASSERT_CYC,    // Master reassertion timeout
    parameter int FILTER_CYC      = `SSFF_FILTER_CYC,      // Fault glitch filter length
    parameter int SYNC_START_CYC  = `SSFF_SYNC_START_CYC,  // Delay before following sync
    parameter int RST_HOLD_CYC    = `SSFF_RST_HOLD_CYC,    // Power-good hold time
    parameter int SS_CYC          = `SSFF_SS_CYC           // Soft-start length
) (
    input  wire logic core_clk_in,                // Core clock, 25 MHz
    input  wire logic nrst_in,                    // Async reset, active low
    input  wire logic sync_clock_input_in,        // External sync pin, async
    input  wire logic in_regulation_in,           // Output within regulation, async
    input  wire logic low_input_warning_in,       // Low input voltage warning, async
    input  wire logic temperature_warning_in,     // High temperature warning, async
    input  wire logic thermal_shutdown_in,        // Over-temperature shutdown, async
    input  wire logic foldback_hv_in,             // Input above foldback threshold, async
    input  wire logic foldback_int_in,            // Internal foldback condition, async
    output logic      switch_on_out,              // Switch turn-on pulse
    output logic      sync_phase_output_out,      // Out-of-phase sync output
    output logic      slaved_out,                 // Timing follows external sync
    output logic      power_good_reset_n_out,     // Power-good reset, active low
    output logic      fault_flag_n_out,           // Fault pin output value (always 0)
    output logic      fault_flag_n_oe_out,        // Fault pin drive enable
    output logic      gate_drive_supply_out,      // Gate drive supply enable
    output logic      soft_start_done_out         // Soft-start complete
);
    // Two-stage synchronisers for all pin inputs
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign raw_w = {foldback_int_in, foldback_hv_in, thermal_shutdown_in, temperature_warning_in,
                    low_input_warning_in, in_regulation_in, sync_clock_input_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge core_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw_w[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    logic sync_s;
    logic inreg_s;
    logic lvi_s;
    logic temperature_warning_s;
    logic tsd_s;
    logic fold_hv_s;
    logic fold_any_s;
    assign sync_s     = s2_q[0];
    assign inreg_s    = s2_q[1];
    assign lvi_s      = s2_q[2];
    assign temperature_warning_s    = s2_q[3];
    assign tsd_s      = s2_q[4];
    assign fold_hv_s  = s2_q[5];
    assign fold_any_s = s2_q[5] | s2_q[6];

    // Sync edge detect on synchronised level
    logic sync_prev_q;
    logic sync_rise;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= sync_s;
        end
    end
    assign sync_rise = sync_s & ~sync_prev_q;

    // Power-good reset hold counter
    logic [31:0] pg_cnt_q;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pg_cnt_q               <= 32'h0000_0000;
            power_good_reset_n_out <= 1'b0;
        end else if (!inreg_s || tsd_s) begin
            pg_cnt_q               <= 32'h0000_0000;
            power_good_reset_n_out <= 1'b0;
        end else if (pg_cnt_q >= 32'(RST_HOLD_CYC - 1)) begin
            power_good_reset_n_out <= 1'b1;
        end else begin
            pg_cnt_q <= pg_cnt_q + 32'h0000_0001;
        end
    end

    // Sync enable delay after power-good release
    logic [31:0] en_cnt_q;
    logic        sync_en_q;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            en_cnt_q  <= 32'h0000_0000;
            sync_en_q <= 1'b0;
        end else if (!power_good_reset_n_out) begin
            en_cnt_q  <= 32'h0000_0000;
            sync_en_q <= 1'b0;
        end else if (en_cnt_q >= 32'(SYNC_START_CYC - 1)) begin
            sync_en_q <= 1'b1;
        end else begin
            en_cnt_q <= en_cnt_q + 32'h0000_0001;
        end
    end

    // Thermal shutdown and soft-start
    logic        run_ok;
    logic [15:0] ss_cnt_q;
    assign run_ok = ~tsd_s;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gate_drive_supply_out <= 1'b0;
            ss_cnt_q              <= 16'h0000;
            soft_start_done_out   <= 1'b0;
        end else if (!run_ok) begin
            gate_drive_supply_out <= 1'b0;
            ss_cnt_q              <= 16'h0000;
            soft_start_done_out   <= 1'b0;
        end else begin
            gate_drive_supply_out <= 1'b1;
            if (ss_cnt_q >= 16'(SS_CYC - 1)) begin
                soft_start_done_out <= 1'b1;
            end else begin
                ss_cnt_q <= ss_cnt_q + 16'h0001;
            end
        end
    end

    // Oscillator source selection
    ssff_pkg::ssff_src_t src_q;
    logic [15:0]         to_cnt_q;
    logic                ext_ok;
    assign ext_ok = sync_en_q & ~fold_any_s & run_ok;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            src_q    <= ssff_pkg::SSFF_SRC_OWN;
            to_cnt_q <= 16'h0000;
        end else begin
            case (src_q)
                ssff_pkg::SSFF_SRC_OWN: begin
                    to_cnt_q <= 16'h0000;
                    if (ext_ok && sync_rise) begin
                        src_q <= ssff_pkg::SSFF_SRC_EXT;
                    end
                end
                ssff_pkg::SSFF_SRC_EXT, ssff_pkg::SSFF_SRC_WAIT: begin
                    if (!ext_ok) begin
                        src_q <= ssff_pkg::SSFF_SRC_OWN;
                    end else if (sync_rise) begin
                        to_cnt_q <= 16'h0000;
                        src_q    <= ssff_pkg::SSFF_SRC_EXT;
                    end else if (to_cnt_q >= 16'(REASSERT_CYC - 1)) begin
                        src_q <= ssff_pkg::SSFF_SRC_OWN;
                    end else begin
                        to_cnt_q <= to_cnt_q + 16'h0001;
                    end
                end
                default: begin
                    src_q <= ssff_pkg::SSFF_SRC_OWN;
                end
            endcase
        end
    end
    assign slaved_out = (src_q != ssff_pkg::SSFF_SRC_OWN);

    // Own oscillator, period doubled in high input voltage foldback (foldback_hv_in only)
    logic [15:0] osc_cnt_q;
    logic [15:0] period;
    logic        osc_tick;
    assign period   = fold_hv_s ? 16'(SW_PERIOD_CYC * `SSFF_FOLDBACK_DIV) : 16'(SW_PERIOD_CYC);
    assign osc_tick = (osc_cnt_q >= period - 16'h0001);
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            osc_cnt_q <= 16'h0000;
        end else if (osc_tick || (ext_ok && sync_rise)) begin
            osc_cnt_q <= 16'h0000;
        end else begin
            osc_cnt_q <= osc_cnt_q + 16'h0001;
        end
    end

    // Switch turn-on pulse and sync output phase
    logic turn_on;
    assign turn_on = run_ok & ((ext_ok && sync_rise) || (!slaved_out && osc_tick));
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            switch_on_out <= 1'b0;
        end else begin
            switch_on_out <= turn_on;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_phase_output_out <= 1'b0;
        end else if (slaved_out || fold_any_s || (ext_ok && sync_rise)) begin
            sync_phase_output_out <= 1'b0;
        end else if (turn_on) begin
            sync_phase_output_out <= 1'b0;
        end else if (osc_cnt_q == (period >> 1) - 16'h0001) begin
            sync_phase_output_out <= 1'b1;
        end
    end

    // Fault flag, filtered, open drain
    logic fault_filt;
    ssff_filter #(
        .LEN (FILTER_CYC)
    ) u_fault_filter (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .raw_in      (lvi_s | temperature_warning_s),
        .filt_out    (fault_filt)
    );
    assign fault_flag_n_out = 1'b0;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fault_flag_n_oe_out <= 1'b0;
        end else begin
            fault_flag_n_oe_out <= fault_filt;
        end
    end
endmodule : ssff_top

// ===== logic/ssff_regs.svh
// Timing constants and counts for the switching sync and fault flag block
`ifndef SSFF_REGS_SVH
`define SSFF_REGS_SVH
`define SSFF_CLK_HZ             25000000
`define SSFF_SYNC_START_US      2500
`define SSFF_SYNC_START_CYC     ((`SSFF_SYNC_START_US * (`SSFF_CLK_HZ / 1000000)))
`define SSFF_RST_HOLD_US        16000
`define SSFF_RST_HOLD_CYC       ((`SSFF_RST_HOLD_US * (`SSFF_CLK_HZ / 1000000)))
`define SSFF_SW_PERIOD_CYC      12
`define SSFF_FOLDBACK_DIV       2
`define SSFF_REASSERT_CYC       32
`define SSFF_FILTER_CYC         4
`define SSFF_SS_CYC             64
`endif

// ===== logic/ssff_pkg.sv
// Types for the switching sync and fault flag block
package ssff_pkg;
    typedef enum logic [1:0] {
        SSFF_SRC_OWN,
        SSFF_SRC_WAIT,
        SSFF_SRC_EXT
    } ssff_src_t;
endpackage : ssff_pkg

// ===== logic/ssff_filter.sv
// Glitch filter: output follows input only after it stays stable for LEN cycles
`timescale 1ns/100ps
module ssff_filter #(
    parameter int LEN = 4
) (
    input  wire logic core_clk_in,  // Core clock
    input  wire logic nrst_in,      // Async reset, active low
    input  wire logic raw_in,       // Unfiltered level, same domain
    output logic      filt_out      // Filtered level
);
    logic [15:0] cnt_q;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q    <= 16'h0000;
            filt_out <= 1'b0;
        end else if (raw_in == filt_out) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q >= 16'(LEN - 1)) begin
            cnt_q    <= 16'h0000;
            filt_out <= raw_in;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : ssff_filter

// ===== tb/ssff_chk.sv
// Concurrent checks on the sync and fault flag block ports
`timescale 1ns/100ps
module ssff_chk #(
    parameter int SYNC_START_CYC = 20,
    parameter int RST_HOLD_CYC   = 50,
    parameter int REASSERT_CYC   = 32
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic sync_clock_input_in,
    input wire logic in_regulation_in,
    input wire logic low_input_warning_in,
    input wire logic temperature_warning_in,
    input wire logic thermal_shutdown_in,
    input wire logic foldback_hv_in,
    input wire logic foldback_int_in,
    input wire logic switch_on_out,
    input wire logic sync_phase_output_out,
    input wire logic slaved_out,
    input wire logic power_good_reset_n_out,
    input wire logic fault_flag_n_out,
    input wire logic fault_flag_n_oe_out,
    input wire logic gate_drive_supply_out,
    input wire logic soft_start_done_out
);
    int  reg_q;
    int  pg_q;
    int  edge_q;
    logic warn;
    assign warn = low_input_warning_in | temperature_warning_in;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // Cycles in regulation, with power good, since last sync edge
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_q  <= 0;
            pg_q   <= 0;
            edge_q <= 0;
        end else begin
            reg_q  <= in_regulation_in ? reg_q + 1 : 0;
            pg_q   <= power_good_reset_n_out ? pg_q + 1 : 0;
            edge_q <= $rose(sync_clock_input_in) ? 0 : edge_q + 1;
        end
    end
    AST_LOW_HALF: assert property ($rose(sync_phase_output_out) |-> !$past(sync_phase_output_out, 5))
        else $error("sync output low for less than half a period");
    AST_SLAVE_LOW: assert property (slaved_out |-> !sync_phase_output_out)
        else $error("sync output high while slaved");
    AST_START_GATE: assert property ($rose(slaved_out) |-> pg_q >= SYNC_START_CYC)
        else $error("slaving began too early");
    AST_EDGE_TURN_ON: assert property (slaved_out && $rose(sync_clock_input_in) |-> ##[2:5] switch_on_out)
        else $error("sync edge gave no turn-on");
    AST_REASSERT: assert property (slaved_out |-> edge_q <= REASSERT_CYC + 6)
        else $error("still slaved after timeout");
    AST_FOLD_LOW: assert property ((foldback_hv_in || foldback_int_in) [*5] |-> !sync_phase_output_out && !slaved_out)
        else $error("sync output or slaving during foldback");
    AST_FLAG_RISE: assert property (warn [*8] |-> ##[0:6] fault_flag_n_oe_out)
        else $error("fault flag not asserted");
    AST_FLAG_FILTER: assert property ($rose(fault_flag_n_oe_out) |-> $past(warn, 4) && $past(warn, 5))
        else $error("fault flag rose without stable warning");
    AST_OPEN_DRAIN: assert property (fault_flag_n_out == 1'b0)
        else $error("fault pin data not low");
    AST_SHUTDOWN: assert property (thermal_shutdown_in [*4] |-> !gate_drive_supply_out && !soft_start_done_out && !switch_on_out)
        else $error("activity during thermal shutdown");
    AST_RESUME: assert property ($fell(thermal_shutdown_in) ##8 !thermal_shutdown_in |-> gate_drive_supply_out)
        else $error("gate drive not restored");
    AST_PG_HOLD: assert property ($rose(power_good_reset_n_out) |-> reg_q >= RST_HOLD_CYC)
        else $error("power good released early");
    cover property ($rose(slaved_out));
    cover property ($rose(fault_flag_n_oe_out));
    cover property ($rose(power_good_reset_n_out));
endmodule : ssff_chk
bind ssff_top ssff_chk #(.SYNC_START_CYC(SYNC_START_CYC), .RST_HOLD_CYC(RST_HOLD_CYC), .REASSERT_CYC(REASSERT_CYC)) i_ssff_chk (
    .core_clk_in, .nrst_in, .sync_clock_input_in, .in_regulation_in, .low_input_warning_in,
    .temperature_warning_in, .thermal_shutdown_in, .foldback_hv_in, .foldback_int_in, .switch_on_out,
    .sync_phase_output_out, .slaved_out, .power_good_reset_n_out, .fault_flag_n_out, .fault_flag_n_oe_out,
    .gate_drive_supply_out, .soft_start_done_out);

// ===== tb/ssff_sync_src.sv
// External sync clock source, 320 ns period while enabled
`timescale 1ns/100ps
module ssff_sync_src (
    input  wire logic en_in,    // Run the clock
    output logic      sync_out  // To sync input pin
);
    initial sync_out = 1'b0;
    // Stands low outside bursts, phase offset from core clock
    always begin
        wait (en_in);
        #167 sync_out = 1'b1;
        #153 sync_out = 1'b0;
    end
endmodule : ssff_sync_src

// ===== tb/switch_sync_and_fault_flags_tb.sv
// Testbench for the sync and fault flag block
`timescale 1ns/100ps
module switch_sync_and_fault_flags_tb;
    localparam int SYNC_START = 20;
    localparam int RST_HOLD   = 50;
    logic clk = 1'b0, nrst = 1'b0, en = 1'b0, inreg = 1'b1, low = 1'b0, temp = 1'b0;
    logic shut = 1'b0, fhv = 1'b0, fint = 1'b0;
    logic sync, so, sync_phase_output, slv, pg, flt, oe, gate, ssd;
    int   fails = 0, checked = 0;
    always #20 clk = ~clk;
    ssff_sync_src i_ssff_sync_src (.en_in(en), .sync_out(sync));
    ssff_top #(.SYNC_START_CYC(SYNC_START), .RST_HOLD_CYC(RST_HOLD)) i_ssff_top (
        .core_clk_in(clk), .nrst_in(nrst), .sync_clock_input_in(sync), .in_regulation_in(inreg),
        .low_input_warning_in(low), .temperature_warning_in(temp), .thermal_shutdown_in(shut),
        .foldback_hv_in(fhv), .foldback_int_in(fint), .switch_on_out(so), .sync_phase_output_out(sync_phase_output),
        .slaved_out(slv), .power_good_reset_n_out(pg), .fault_flag_n_out(flt), .fault_flag_n_oe_out(oe),
        .gate_drive_supply_out(gate), .soft_start_done_out(ssd));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    // Cycles between two turn-on pulses
    task automatic per(output logic [31:0] n);
        n = 0;
        while (so !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        n = 1;
        while (so !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask : per
    task automatic t_sync;
        logic [31:0] n;
        n = 0;
        en = 1'b1;
        while (pg !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("pg_delay_ok", n >= RST_HOLD, 1'b1);
        n = 0;
        while (slv !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("sync_start_ok", n <= SYNC_START + 8, 1'b1);
        chk("sync_phase_output_slaved", sync_phase_output, 1'b0);
        per(n);
        chk("slaved_period", n, 32'h8);
        en = 1'b0;
        repeat (45) @(negedge clk);
        chk("slaved_off", slv, 1'b0);
        per(n);
        per(n);
        chk("own_period", n, 32'hc);
        @(negedge clk);
        chk("sync_phase_output_fall", sync_phase_output, 1'b0);
        repeat (6) @(negedge clk);
        chk("sync_phase_output_rise", sync_phase_output, 1'b1);
    endtask : t_sync
    task automatic t_fold;
        logic [31:0] n;
        fhv = 1'b1;
        per(n);
        per(n);
        chk("fold_period", n, 32'h18);
        fhv = 1'b0;
        per(n);
        per(n);
        chk("restored_period", n, 32'hc);
        fint = 1'b1;
        en = 1'b1;
        repeat (40) @(negedge clk);
        chk("fold_slaved", slv, 1'b0);
        chk("fold_sync_phase_output", sync_phase_output, 1'b0);
        en = 1'b0;
        fint = 1'b0;
        repeat (40) @(negedge clk);
    endtask : t_fold
    task automatic t_fault;
        low = 1'b1;
        repeat (2) @(negedge clk);
        low = 1'b0;
        repeat (20) @(negedge clk);
        chk("flag_glitch", oe, 1'b0);
        low = 1'b1;
        repeat (20) @(negedge clk);
        chk("flag_low_in", oe, 1'b1);
        chk("flag_data", flt, 1'b0);
        low = 1'b0;
        temp = 1'b1;
        repeat (20) @(negedge clk);
        chk("flag_temp", oe, 1'b1);
        temp = 1'b0;
        repeat (20) @(negedge clk);
        chk("flag_clear", oe, 1'b0);
    endtask : t_fault
    task automatic t_therm;
        chk("ss_done_before", ssd, 1'b1);
        chk("gate_before", gate, 1'b1);
        shut = 1'b1;
        repeat (10) @(negedge clk);
        chk("shut_gate", gate, 1'b0);
        chk("shut_ss", ssd, 1'b0);
        shut = 1'b0;
        repeat (10) @(negedge clk);
        chk("resume_gate", gate, 1'b1);
    endtask : t_therm
    task automatic complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    initial begin
        #(40 * 5000);
        fails++;
        complete_run;
    end
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        t_sync;
        t_fold;
        t_fault;
        t_therm;
        complete_run;
    end
endmodule : switch_sync_and_fault_flags_tb
